// File: rtl/bpc_config_header.sv
// Configuration header of the bridge function: status, identity,
// class, header type, boot strap capture and identity write lock.
// Assumes a decoded configuration port on the same clock as the
// bus, event strobes from bus logic on that clock, and strap pins
// arriving asynchronously.
`timescale 1ns/1ns

module bpc_config_header #(
    parameter logic [7:0] REV_RST = 8'hA5, // Arbitrary value
    parameter logic [15:0] SUBSYSTEM_VENDOR_CODE_RST = 16'h1C3B, // Arbitrary value
    parameter logic [15:0] SUBSYSTEM_PRODUCT_CODE_RST = 16'h5E7D // Arbitrary value
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Configuration access port
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [5:0] cfg_dw,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // Bus event strobes
    input wire logic parity_err_evt,
    input wire logic serr_drive_evt,
    input wire logic master_abort_evt,
    input wire logic special_cycle,
    input wire logic target_abort_evt,
    // Strap pins
    input wire logic [1:0] rom_kind_strap,
    // State seen by the rest of the chip
    output logic [1:0] boot_rom_location,
    output logic id_write_unlock
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Dword indices derived from the byte offsets
    localparam logic [5:0] DW_STATUS = bpc_pkg::BPC_OFF_STATUS[7:2];
    localparam logic [5:0] DW_REV = bpc_pkg::BPC_OFF_REV[7:2];
    localparam logic [5:0] DW_HDR = bpc_pkg::BPC_OFF_HDR[7:2];
    localparam logic [5:0] DW_SUB = bpc_pkg::BPC_OFF_SUBSYSTEM_VENDOR_CODE[7:2];
    localparam logic [5:0] DW_BOOT = bpc_pkg::BPC_OFF_BOOT[7:2];
    // Lanes of the byte-addressed fields
    localparam int LN_STAT_HI = 3;
    localparam int LN_REV = 0;
    localparam int LN_SUBSYSTEM_VENDOR_CODE = 0;
    localparam int LN_SUBSYSTEM_PRODUCT_CODE = 2;
    localparam int LN_LOCK = 1;

    // Write strobes per target, before the lock is applied
    logic wr_any;
    logic wr_status;
    logic wr_rev;
    logic wr_sub;
    logic wr_lock;

    // A write is taken only on an enabled edge
    assign wr_any = ce && cfg_req && cfg_wr;
    assign wr_status = wr_any && (cfg_dw == DW_STATUS);
    assign wr_rev = wr_any && (cfg_dw == DW_REV);
    assign wr_sub = wr_any && (cfg_dw == DW_SUB);
    assign wr_lock = wr_any && (cfg_dw == DW_BOOT);

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    logic [3:0] flags_reg; // Bits 15..12 of status
    logic [3:0] flags_next;
    logic [3:0] flags_set;
    logic [3:0] flags_clr;
    logic [15:0] status_view;

    // Event collection and write-one-to-clear
    always_comb begin
        flags_set = {parity_err_evt,
                     serr_drive_evt,
                     master_abort_evt && !special_cycle,
                     target_abort_evt};
        // Only the top byte lane can clear, and only with a one
        flags_clr = '0;
        if (wr_status && cfg_be[LN_STAT_HI]) begin
            flags_clr = cfg_wdata[31:28];
        end
        // Set wins over clear so no event is lost
        flags_next = (flags_reg & ~flags_clr) | flags_set;
        if (!ce) begin
            flags_next = flags_reg;
        end
    end

    // Flags register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags_reg <= bpc_pkg::BPC_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Status as software reads it
    always_comb begin
        status_view = '0;
        status_view[bpc_pkg::BPC_ST_PERR] = flags_reg[3];
        status_view[bpc_pkg::BPC_ST_SERR] = flags_reg[2];
        status_view[bpc_pkg::BPC_ST_MABT] = flags_reg[1];
        status_view[bpc_pkg::BPC_ST_TABT] = flags_reg[0];
        // This function never aborts as a target
        status_view[bpc_pkg::BPC_ST_TSIG] = bpc_pkg::BPC_TSIG_VALUE;
        status_view[bpc_pkg::BPC_ST_SEL_HI:bpc_pkg::BPC_ST_SEL_LO] =
            bpc_pkg::BPC_SEL_TIMING;
    end

    // ----------------------------------------------------------------
    // Identity registers and write lock
    // ----------------------------------------------------------------
    logic [7:0] rev_reg;
    logic [7:0] rev_next;
    logic [15:0] subsystem_vendor_code_reg;
    logic [15:0] subsystem_vendor_code_next;
    logic [15:0] subsystem_product_code_reg;
    logic [15:0] subsystem_product_code_next;
    logic lock_reg; // One means identity registers are writable
    logic lock_next;

    // Byte-wise updates, gated by the unlock bit
    always_comb begin
        rev_next = rev_reg;
        subsystem_vendor_code_next = subsystem_vendor_code_reg;
        subsystem_product_code_next = subsystem_product_code_reg;
        lock_next = lock_reg;
        // Locked: identity writes vanish with no error reported
        if (lock_reg) begin
            if (wr_rev && cfg_be[LN_REV]) begin
                rev_next = cfg_wdata[7:0];
            end
            for (int b = 0; b < 2; b++) begin
                if (wr_sub && cfg_be[LN_SUBSYSTEM_VENDOR_CODE + b]) begin
                    subsystem_vendor_code_next[8*b +: 8] =
                        cfg_wdata[8*(LN_SUBSYSTEM_VENDOR_CODE + b) +: 8];
                end
                if (wr_sub && cfg_be[LN_SUBSYSTEM_PRODUCT_CODE + b]) begin
                    subsystem_product_code_next[8*b +: 8] =
                        cfg_wdata[8*(LN_SUBSYSTEM_PRODUCT_CODE + b) +: 8];
                end
            end
        end
        // The lock bit itself is always writable
        if (wr_lock && cfg_be[LN_LOCK]) begin
            lock_next = cfg_wdata[8];
        end
    end

    // Identity and lock registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rev_reg <= REV_RST;
            subsystem_vendor_code_reg <= SUBSYSTEM_VENDOR_CODE_RST;
            subsystem_product_code_reg <= SUBSYSTEM_PRODUCT_CODE_RST;
            lock_reg <= bpc_pkg::BPC_LOCK_RST;
        end else if (ce) begin
            rev_reg <= rev_next;
            subsystem_vendor_code_reg <= subsystem_vendor_code_next;
            subsystem_product_code_reg <= subsystem_product_code_next;
            lock_reg <= lock_next;
        end
    end

    // ----------------------------------------------------------------
    // Strap synchroniser and capture
    // ----------------------------------------------------------------
    // Chain runs through reset so the pins have settled at release
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    logic [1:0] strap_s3_reg;
    logic [1:0] strap_ok_reg; // Filtered level
    logic [1:0] strap_ok_next;
    logic in_reset_reg; // High on the first edge after release
    logic [1:0] boot_reg;
    logic [1:0] boot_next;

    // A change counts once stages two and three agree, bit by bit
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            strap_ok_next[i] = (strap_s2_reg[i] == strap_s3_reg[i]) ?
                strap_s3_reg[i] : strap_ok_reg[i];
        end
        // Level copied as is: low gives zero, high gives one
        boot_next = in_reset_reg ? strap_ok_reg : boot_reg;
    end

    // Synchroniser stages, no reset on purpose
    always_ff @(posedge clk) begin
        if (ce) begin
            strap_s1_reg <= rom_kind_strap;
            strap_s2_reg <= strap_s1_reg;
            strap_s3_reg <= strap_s2_reg;
            strap_ok_reg <= strap_ok_next;
        end
    end

    // Capture flag and boot location
    always_ff @(posedge clk) begin
        if (!rstn) begin
            in_reset_reg <= 1'b1;
            boot_reg <= bpc_pkg::BPC_BOOT_RST;
        end else if (ce) begin
            in_reset_reg <= 1'b0;
            boot_reg <= boot_next;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [31:0] rdata_next;
    logic ack_next;

    // Fields left out of this block read as zero
    always_comb begin
        case (cfg_dw)
            DW_STATUS: rdata_next = {status_view, 16'h0000};
            DW_REV: rdata_next = {bpc_pkg::BPC_CLASS_CODE, rev_reg};
            DW_HDR: rdata_next = {8'h00, bpc_pkg::BPC_HDR_LAYOUT,
                                  16'h0000};
            DW_SUB: rdata_next = {subsystem_product_code_reg, subsystem_vendor_code_reg};
            DW_BOOT: rdata_next = {16'h0000, 7'h00, lock_reg, 6'h00, boot_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
        // Reads show the value before a same-cycle write
        if (!(cfg_req && !cfg_wr)) begin
            rdata_next = cfg_rdata;
        end
        ack_next = cfg_req;
    end

    // Answer registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack <= 1'b0;
        end else if (ce) begin
            cfg_rdata <= rdata_next;
            cfg_ack <= ack_next;
        end
    end

    assign boot_rom_location = boot_reg;
    assign id_write_unlock = lock_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic rd_take;
    assign rd_take = ce && cfg_req && !cfg_wr;

    AST_PERR_SETS:
    assert property (ce && parity_err_evt |=> flags_reg[3])
        else $error("parity flag not set");
    AST_SERR_SETS:
    assert property (ce && serr_drive_evt |=> flags_reg[2])
        else $error("system error flag not set");
    AST_MABT_SPECIAL:
    assert property (ce && master_abort_evt && special_cycle
                     && !flags_reg[1] |=> !flags_reg[1])
        else $error("special cycle set master abort flag");
    AST_TABT_SETS:
    assert property (ce && target_abort_evt |=> flags_reg[0])
        else $error("target abort flag not set");
    AST_W1C_CLEARS:
    assert property (wr_status && cfg_be[3] && cfg_wdata[31]
                     && !parity_err_evt |=> !flags_reg[3])
        else $error("write one did not clear flag");
    AST_ZERO_KEEPS:
    assert property (wr_status && cfg_be[3] && !cfg_wdata[30]
                     && flags_reg[2] |=> flags_reg[2])
        else $error("write zero changed flag");
    AST_STATUS_FIXED:
    assert property (rd_take && cfg_dw == DW_STATUS
                     |=> cfg_ack && cfg_rdata[27:16] == 12'h600)
        else $error("fixed status bits wrong");
    AST_LOCK_HOLDS:
    assert property (wr_any && !lock_reg
                     |=> $stable(rev_reg) && $stable(subsystem_vendor_code_reg)
                         && $stable(subsystem_product_code_reg))
        else $error("locked identity register changed");
    AST_REV_WRITES:
    assert property (wr_rev && cfg_be[0] && lock_reg
                     |=> rev_reg == $past(cfg_wdata[7:0]))
        else $error("unlocked revision write lost");
    AST_CLASS_READ:
    assert property (rd_take && cfg_dw == DW_REV
                     |=> cfg_rdata[31:8] == 24'h060100)
        else $error("class code wrong");
    AST_BOOT_STABLE:
    assert property (!in_reset_reg ##1 !in_reset_reg |-> $stable(boot_reg))
        else $error("boot location moved after capture");

    COV_PERR_CLEAR: cover property (flags_reg[3] ##1 !flags_reg[3]);
    COV_UNLOCK_WRITE: cover property (wr_rev && lock_reg);
    COV_LOCKED_WRITE: cover property (wr_sub && !lock_reg);
    COV_SET_AND_CLEAR: cover property (wr_status && cfg_be[3]
                                       && cfg_wdata[31] && parity_err_evt);

endmodule

// File: rtl/bpc_pkg.sv
// Constants for the bridge function's PCI configuration header block.
// Assumes byte offsets inside a 256-byte configuration space, with
// dword-wide accesses carrying four byte enables.
package bpc_pkg;

    // ----------------------------------------------------------------
    // Byte offsets of the implemented registers
    // ----------------------------------------------------------------
    localparam logic [7:0] BPC_OFF_STATUS = 8'h06; // Bus error status
    localparam logic [7:0] BPC_OFF_REV = 8'h08; // Revision number
    localparam logic [7:0] BPC_OFF_CLASS = 8'h09; // Class code, 3 bytes
    localparam logic [7:0] BPC_OFF_HDR = 8'h0E; // Header layout type
    localparam logic [7:0] BPC_OFF_SUBSYSTEM_VENDOR_CODE = 8'h2C; // Subsystem vendor code
    localparam logic [7:0] BPC_OFF_SUBSYSTEM_PRODUCT_CODE = 8'h2E; // Subsystem product code
    localparam logic [7:0] BPC_OFF_BOOT = 8'h40; // Boot strap capture
    localparam logic [7:0] BPC_OFF_LOCK = 8'h41; // Identity write lock

    // ----------------------------------------------------------------
    // Status field positions (within the 16-bit status register)
    // ----------------------------------------------------------------
    localparam int BPC_ST_PERR = 15; // Parity error detected
    localparam int BPC_ST_SERR = 14; // System error signalled
    localparam int BPC_ST_MABT = 13; // Master abort received
    localparam int BPC_ST_TABT = 12; // Target abort received
    localparam int BPC_ST_TSIG = 11; // Target abort signalled
    localparam int BPC_ST_SEL_LO = 9; // Select timing, low bit
    localparam int BPC_ST_SEL_HI = 10; // Select timing, high bit

    // ----------------------------------------------------------------
    // Fixed and reset values
    // ----------------------------------------------------------------
    localparam logic [23:0] BPC_CLASS_CODE = 24'h060100;
    localparam logic [7:0] BPC_HDR_LAYOUT = 8'h00;
    localparam logic [1:0] BPC_SEL_TIMING = 2'h3;
    localparam logic BPC_TSIG_VALUE = 1'b0;
    localparam logic [3:0] BPC_FLAGS_RST = 4'h0;
    localparam logic [1:0] BPC_BOOT_RST = 2'h0;
    localparam logic BPC_LOCK_RST = 1'b0;

    // ----------------------------------------------------------------
    // Boot ROM location encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] BPC_ROM_XBUS8 = 2'h0;
    localparam logic [1:0] BPC_ROM_XBUS16 = 2'h1;
    localparam logic [1:0] BPC_ROM_LPC = 2'h2;
    localparam logic [1:0] BPC_ROM_LPC_FWH = 2'h3;

endpackage

// File: test/bpc_host_model.sv
// Host-side model: a configuration master issuing one dword access at
// a time on the block's decoded port and waiting for its acknowledge.
// Assumes the block answers within a few cycles of taking a request.
`timescale 1ns/1ns

module bpc_host_model (
    // Clock
    input wire logic clk,
    // Answer from the block
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // Request to the block
    output logic cfg_req,
    output logic cfg_wr,
    output logic [5:0] cfg_dw,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    // Idle pattern until the first access
    initial begin
        cfg_req = 1'b0;
        cfg_wr = 1'b0;
        cfg_dw = 6'h2A;
        cfg_be = 4'h5;
        cfg_wdata = 32'hA5A5_5A5A;
    end

    // One access: request held for the taking edge, then released
    task automatic access(input logic wr, input logic [5:0] dw,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic [31:0] rdata, output logic got);
        got = 1'b0;
        rdata = 32'h0;
        @(posedge clk);
        #1;
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_dw = dw;
        cfg_be = be;
        cfg_wdata = wd;
        @(posedge clk);
        #1;
        // Inverted lines after release, so stale values never pass
        cfg_req = 1'b0;
        cfg_wr = ~wr;
        cfg_dw = ~dw;
        cfg_be = ~be;
        cfg_wdata = ~wd;
        for (int n = 0; n < 4 && !got; n++) begin
            if (cfg_ack === 1'b1) begin
                rdata = cfg_rdata;
                got = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask

    // Firmware order: open identity registers, program, then lock
    task automatic fw_program(logic [7:0] rv, logic [15:0] sv,
                              logic [15:0] sd);
        logic [31:0] r;
        logic g;
        access(1'b1, 6'h10, 4'h2, 32'h0000_0100, r, g);
        access(1'b1, 6'h02, 4'h1, {24'h0, rv}, r, g);
        access(1'b1, 6'h0B, 4'hF, {sd, sv}, r, g);
        access(1'b1, 6'h10, 4'h2, 32'h0, r, g);
    endtask
endmodule

// File: test/bridge_pci_config_header_tb_top.sv
// Testbench for the configuration header: straps, fixed values,
// status flags and the identity lock. Assumes bpc_pkg, the block and
// the host model are compiled first.
`timescale 1ns/1ns

module bridge_pci_config_header_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0; // 50 MHz clock
    logic rstn = 1'b0; // Reset, low active
    logic ce = 1'b1; // Enable held high throughout
    logic [3:0] evt_vec = 4'h0; // Parity, serr, mabort, tabort
    logic special_cycle = 1'b0; // Marks master abort as special
    logic [1:0] strap = 2'h0; // Strap pin levels
    logic cfg_req, cfg_wr, cfg_ack, ok, id_write_unlock;
    logic [5:0] cfg_dw;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic [1:0] boot_rom_location;
    int err_count = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    bpc_config_header dut (.clk(clk), .rstn(rstn), .ce(ce),
        .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_dw(cfg_dw),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .parity_err_evt(evt_vec[3]),
        .serr_drive_evt(evt_vec[2]), .master_abort_evt(evt_vec[1]),
        .special_cycle(special_cycle), .target_abort_evt(evt_vec[0]),
        .rom_kind_strap(strap), .boot_rom_location(boot_rom_location),
        .id_write_unlock(id_write_unlock));

    bpc_host_model host (.clk(clk), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_dw(cfg_dw), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(string name, logic [31:0] seen,
                         logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read a dword; the acknowledge must arrive as well
    task automatic rd_chk(string name, logic [5:0] dw, logic [31:0] exp);
        host.access(1'b0, dw, 4'hF, 32'h0, rd, ok);
        check("read_ack", {31'h0, ok}, 32'h1);
        check(name, rd, exp);
    endtask

    task automatic wr(logic [5:0] dw, logic [3:0] be, logic [31:0] d);
        host.access(1'b1, dw, be, d, rd, ok);
        check("write_ack", {31'h0, ok}, 32'h1);
    endtask

    // Eight cycles of reset with the straps already settled
    task automatic do_reset(logic [1:0] v);
        @(posedge clk);
        #1;
        rstn = 1'b0;
        strap = v;
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        @(posedge clk);
        #1;
    endtask

    task automatic pulse(logic [3:0] v, logic sc);
        @(posedge clk);
        #1;
        evt_vec = v;
        special_cycle = sc;
        @(posedge clk);
        #1;
        evt_vec = 4'h0;
        special_cycle = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every encoding; a later strap change must not leak through
    task automatic t_straps;
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1:0]);
            strap = ~i[1:0];
            repeat (6) @(posedge clk);
            #1;
            check("boot", {30'h0, boot_rom_location}, i);
            rd_chk("boot_reg", 6'h10, i);
        end
    endtask

    // Fixed fields survive writes; locked identity ignores them
    task automatic t_fixed;
        rd_chk("status", 6'h01, 32'h0600_0000);
        rd_chk("header", 6'h03, 32'h0);
        rd_chk("subsys", 6'h0B, 32'h5E7D_1C3B);
        rd_chk("unmapped", 6'h3F, 32'h0);
        wr(6'h01, 4'hF, 32'h09FF_FFFF);
        wr(6'h02, 4'hF, 32'hFFFF_FF5A);
        wr(6'h03, 4'hF, 32'hFFFF_FFFF);
        wr(6'h0B, 4'hF, 32'h0);
        rd_chk("status_ro", 6'h01, 32'h0600_0000);
        rd_chk("rev_class", 6'h02, 32'h0601_00A5);
        rd_chk("header_ro", 6'h03, 32'h0);
        rd_chk("subsys_ro", 6'h0B, 32'h5E7D_1C3B);
    endtask

    // Each event sets its flag; one-writes clear, zero-writes keep
    task automatic t_flags;
        for (int i = 0; i < 4; i++) begin
            pulse(4'h8 >> i, 1'b0);
            rd_chk("flag_set", 6'h01,
                   32'h0600_0000 | (32'h8000_0000 >> i));
            wr(6'h01, 4'h8, 32'h8000_0000 >> i);
            rd_chk("flag_clr", 6'h01, 32'h0600_0000);
        end
        pulse(4'h2, 1'b1);
        rd_chk("special", 6'h01, 32'h0600_0000);
        pulse(4'hF, 1'b0);
        wr(6'h01, 4'h7, 32'hF000_0000);
        rd_chk("lane_off", 6'h01, 32'hF600_0000);
        wr(6'h01, 4'h8, 32'h0);
        rd_chk("zero_wr", 6'h01, 32'hF600_0000);
        wr(6'h01, 4'h8, 32'h5000_0000);
        rd_chk("part_clr", 6'h01, 32'hA600_0000);
        fork
            wr(6'h01, 4'h8, 32'hA000_0000);
            pulse(4'h8, 1'b0);
        join
        rd_chk("set_wins", 6'h01, 32'h8600_0000);
        wr(6'h01, 4'h8, 32'h8000_0000);
        rd_chk("all_clr", 6'h01, 32'h0600_0000);
    endtask

    // Unlock, partial lanes, firmware sequence, then locked again
    task automatic t_lock;
        wr(6'h10, 4'h2, 32'h0000_0100);
        check("unlock", {31'h0, id_write_unlock}, 32'h1);
        wr(6'h02, 4'hF, 32'hFFFF_FF3C);
        wr(6'h0B, 4'h5, 32'h1122_3344);
        rd_chk("rev_open", 6'h02, 32'h0601_003C);
        rd_chk("be_split", 6'h0B, 32'h5E22_1C44);
        host.fw_program(8'h7E, 16'hBEEF, 16'hCAFE);
        check("locked", {31'h0, id_write_unlock}, 32'h0);
        wr(6'h02, 4'h1, 32'h0000_0011);
        wr(6'h0B, 4'hF, 32'h0);
        rd_chk("rev_kept", 6'h02, 32'h0601_007E);
        rd_chk("id_kept", 6'h0B, 32'hCAFE_BEEF);
    endtask

    // ------------------------------------------------------------
    // Run
    // ------------------------------------------------------------
    initial begin
        t_straps();
        t_fixed();
        t_flags();
        t_lock();
        give_verdict();
    end

    // Watchdog: the run needs well under 2000 cycles
    initial begin
        #(20 * 5000);
        err_count++;
        give_verdict();
    end
endmodule
